// [common/tmr_cfg.svh]
`ifndef TMR_CFG_SVH
`define TMR_CFG_SVH
// register offsets
`define OFS_FLAGS 8'h0C
`define OFS_CNT_LO 8'h0E
`define OFS_CNT_HI 8'h0F
`define OFS_CTRL 8'h10
`define OFS_ENABLES 8'h8C
// counter_control fields
`define CTL_RUN 0
`define CTL_CLKSRC 1
`define CTL_SYNC_BYPASS 2
`define CTL_OSC_EN 3
`define CTL_PS_LO 4
`define CTL_PS_HI 5
`define CTL_MASK 8'h3F
// flag and enable bit of the overflow
`define OVF_BIT 0
// compare unit special event mode code
`define CMP_MODE_SPECIAL 4'hB
// reset values and the count maximum
`define CTRL_RST 8'h00
`define BYTE_ZERO 8'h00
`define CNT_ZERO 16'h0000
`define CNT_MAX 16'hFFFF
`define PS_ZERO 3'h0
`endif

// [common/tmr_pkg.sv]
package tmr_pkg;
	// prescale ratio selection
	typedef enum logic [1:0] {
		PS_DIV1 = 2'b00,
		PS_DIV2 = 2'b01,
		PS_DIV4 = 2'b10,
		PS_DIV8 = 2'b11
	} prescale_t;
	// source of each counter increment
	typedef enum logic [2:0] {
		SRC_INTERNAL = 3'b001,
		SRC_EXT_SYNC = 3'b010,
		SRC_EXT_ASYNC = 3'b100
	} src_mode_t;
endpackage : tmr_pkg

// [rtl/edge_sampler.sv]
`timescale 1ns/1ps
// =====================================================
// two-flop synchroniser and rising-edge detector
module edge_sampler (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// asynchronous level in
	input wire logic i_level,
	// synchronised level and rising-edge pulse
	output logic o_level,
	output logic o_rise
);
	logic meta_q;
	logic meta_d;
	logic sync_q;
	logic sync_d;
	logic prev_q;
	logic prev_d;

	// next values; first flop feeds only the second
	always_comb begin
		meta_d = i_level;
		sync_d = meta_q;
		prev_d = sync_q;
	end

	// registers
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			prev_q <= 1'b0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			prev_q <= prev_d;
		end
	end

	assign o_level = sync_q;
	assign o_rise = sync_q & ~prev_q;
endmodule : edge_sampler

// [rtl/timer16.sv]
// Operation
// - sync_bypass set: external clock counted without phase-clock sync (here edges still pass the two-flop sampler; bypass drops sleep gate and trigger reset)
// - async mode keeps counting in sleep; overflow can wake processor
// - async counter is not a capture/compare time base
// - byte reads while counting async always return clean values
// - crystal_osc_enable at bit 3 enables oscillator, runs in sleep
// - compare unit in mode 1011 resets the count on trigger
// - special event reset never sets overflow_flag
// - special event reset guaranteed only in timer or synced mode
// - count write wins over a simultaneous special event trigger
// - compare value acts as period; count wraps to zero on match
// - count bytes survive all resets; only triggers clear them
// - power-on and brown-out resets clear counter_control to 00h
// - any write to a count byte clears the prescaler
// - count runs 0000h to FFFFh, wraps, wrap sets overflow_flag
// - clock_source_select picks instruction cycle or external edges
// - prescale field bits 5:4 selects 1:1, 1:2, 1:4, 1:8
// - counter_run bit 0 enables counting
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`include "tmr_cfg.svh"
module timer16
	import tmr_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	// clock and resets
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_por_reset,
	input wire logic i_brown_out_reset,
	// register port
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	// instruction cycle tick and sleep state
	input wire logic i_insn_tick,
	input wire logic i_sleep,
	// external clock pins
	input wire logic i_ext_clk,
	input wire logic i_crystal_in_pin,
	output logic o_crystal_drive_pin,
	// compare units
	input wire logic [3:0] i_cmp_a_mode,
	input wire logic i_cmp_a_match,
	input wire logic [3:0] i_cmp_b_mode,
	input wire logic i_cmp_b_match,
	// count and interrupt out
	output logic [15:0] o_count,
	output logic o_irq,
	output logic o_wake
);
	// the decoder compares full 8-bit offsets
	if (ADDR_W < 8) begin : g_addr_chk
		$error("ADDR_W must be at least 8");
	end

	// =====================================================
	// external clock input
	logic [7:0] ctrl_q;
	logic osc_q;
	logic osc_d;
	logic xtal_level;
	logic xtal_rise;
	logic pin_rise;
	logic ext_rise;

	// oscillator pin only toggles while enabled, so it dies in sleep only
	// when software shuts it off
	always_comb begin
		osc_d = ctrl_q[`CTL_OSC_EN] ? ~xtal_level : 1'b0;
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset)
			osc_q <= 1'b0;
		else
			osc_q <= osc_d;
	end

	// both pins pass two flops before any logic chooses between them
	edge_sampler u_ext (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_level(i_ext_clk),
		.o_level(),
		.o_rise(pin_rise)
	);

	edge_sampler u_xtal (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_level(i_crystal_in_pin),
		.o_level(xtal_level),
		.o_rise(xtal_rise)
	);

	assign ext_rise = ctrl_q[`CTL_OSC_EN] ? xtal_rise : pin_rise;

	// =====================================================
	// control register and increment source
	logic [7:0] ctrl_d;
	logic wr_lo;
	logic wr_hi;
	logic wr_ctl;
	src_mode_t mode;

	assign wr_lo = i_wr && (i_addr[7:0] == `OFS_CNT_LO);
	assign wr_hi = i_wr && (i_addr[7:0] == `OFS_CNT_HI);
	assign wr_ctl = i_wr && (i_addr[7:0] == `OFS_CTRL);

	// source choice; bypass bit only matters on external clock
	always_comb begin
		if (!ctrl_q[`CTL_CLKSRC])
			mode = SRC_INTERNAL;
		else if (ctrl_q[`CTL_SYNC_BYPASS])
			mode = SRC_EXT_ASYNC;
		else
			mode = SRC_EXT_SYNC;
	end

	// control cleared only by power-on or brown-out reset; the plain
	// reset must leave it alone, so the register has no reset branch
	always_comb begin
		ctrl_d = ctrl_q;
		if (wr_ctl)
			ctrl_d = i_wdata & `CTL_MASK;
		if (i_por_reset || i_brown_out_reset)
			ctrl_d = `CTRL_RST;
	end

	always_ff @(posedge i_clk) begin
		ctrl_q <= ctrl_d;
	end

	// =====================================================
	// prescaler and counter
	logic [2:0] ps_q;
	logic [2:0] ps_d;
	logic [15:0] cnt_q;
	logic [15:0] cnt_d;
	logic ovf_q;
	logic ovf_d;
	logic [7:0] ien_q;
	logic [7:0] ien_d;
	logic in_pulse;
	logic ps_out;
	logic trig;
	logic trig_ok;

	// async edges keep arriving in sleep; synced path halts in sleep
	always_comb begin
		case (mode)
			SRC_INTERNAL: in_pulse = i_insn_tick && !i_sleep;
			SRC_EXT_SYNC: in_pulse = ext_rise && !i_sleep;
			SRC_EXT_ASYNC: in_pulse = ext_rise;
			default: in_pulse = 1'b0;
		endcase
	end

	always_comb begin
		case (prescale_t'(ctrl_q[`CTL_PS_HI:`CTL_PS_LO]))
			PS_DIV1: ps_out = in_pulse;
			PS_DIV2: ps_out = in_pulse && (ps_q[0] == 1'b1);
			PS_DIV4: ps_out = in_pulse && (ps_q[1:0] == 2'b11);
			PS_DIV8: ps_out = in_pulse && (ps_q == 3'b111);
			default: ps_out = in_pulse;
		endcase
	end

	// special event from either compare unit
	assign trig = (i_cmp_a_match && i_cmp_a_mode == `CMP_MODE_SPECIAL) ||
		(i_cmp_b_match && i_cmp_b_mode == `CMP_MODE_SPECIAL);
	// trigger not honoured in async counter mode
	assign trig_ok = trig && (mode != SRC_EXT_ASYNC);

	always_comb begin
		ps_d = ps_q;
		cnt_d = cnt_q;
		ovf_d = ovf_q;
		ien_d = ien_q;
		// run bit gates the prescaler and count
		if (ctrl_q[`CTL_RUN] && in_pulse)
			ps_d = ps_q + 3'h1;
		if (ctrl_q[`CTL_RUN] && ps_out) begin
			cnt_d = cnt_q + 16'h0001;
			if (cnt_q == `CNT_MAX)
				ovf_d = 1'b1;
		end
		if (trig_ok)
			cnt_d = `CNT_ZERO;
		// write beats trigger; write clears prescaler
		if (wr_lo) begin
			cnt_d[7:0] = i_wdata;
			ps_d = `PS_ZERO;
		end
		if (wr_hi) begin
			cnt_d[15:8] = i_wdata;
			ps_d = `PS_ZERO;
		end
		// flag write; a same-cycle overflow still sets it
		if (i_wr && i_addr[7:0] == `OFS_FLAGS)
			ovf_d = i_wdata[`OVF_BIT] ||
				(ctrl_q[`CTL_RUN] && ps_out && cnt_q == `CNT_MAX);
		if (i_wr && i_addr[7:0] == `OFS_ENABLES)
			ien_d = i_wdata;
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			ps_q <= `PS_ZERO;
			ovf_q <= 1'b0;
			ien_q <= `BYTE_ZERO;
		end else begin
			ps_q <= ps_d;
			ovf_q <= ovf_d;
			ien_q <= ien_d;
		end
	end

	// count has no reset branch: all resets leave it alone
	always_ff @(posedge i_clk) begin
		cnt_q <= cnt_d;
	end

	// =====================================================
	// read port and outputs
	logic [7:0] rdata_d;
	logic [7:0] rdata_q;
	logic irq_q;
	logic irq_d;
	logic [15:0] cnt_out_q;

	// reads come from the clock-domain count, never torn
	always_comb begin
		rdata_d = `BYTE_ZERO;
		if (i_rd) begin
			case (i_addr[7:0])
				`OFS_FLAGS: rdata_d = {7'h00, ovf_q};
				`OFS_CNT_LO: rdata_d = cnt_q[7:0];
				`OFS_CNT_HI: rdata_d = cnt_q[15:8];
				`OFS_CTRL: rdata_d = ctrl_q;
				`OFS_ENABLES: rdata_d = ien_q;
				default: rdata_d = `BYTE_ZERO;
			endcase
		end
	end

	// interrupt gated by enable; same line wakes from sleep
	always_comb begin
		irq_d = ovf_d && ien_d[`OVF_BIT];
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			rdata_q <= `BYTE_ZERO;
			irq_q <= 1'b0;
			cnt_out_q <= `CNT_ZERO;
		end else begin
			rdata_q <= rdata_d;
			irq_q <= irq_d;
			cnt_out_q <= cnt_d;
		end
	end

	assign o_rdata = rdata_q;
	assign o_irq = irq_q;
	assign o_wake = irq_q;
	assign o_count = cnt_out_q;
	assign o_crystal_drive_pin = osc_q;

	// =====================================================
	// assertions
	sequence s_trig_nowr;
		trig_ok && !wr_lo && !wr_hi;
	endsequence

	a_trig_clears: assert property (@(posedge i_clk) disable iff (i_reset)
		s_trig_nowr |=> cnt_q == `CNT_ZERO)
		else $error("trigger did not clear count");
	a_trig_noflag: assert property (@(posedge i_clk) disable iff (i_reset)
		(trig_ok && !(ctrl_q[`CTL_RUN] && ps_out) && !ovf_q &&
		!(i_wr && i_addr[7:0] == `OFS_FLAGS)) |=> !ovf_q)
		else $error("trigger set overflow flag");
	a_write_wins: assert property (@(posedge i_clk) disable iff (i_reset)
		(wr_lo && trig_ok) |=> cnt_q[7:0] == $past(i_wdata))
		else $error("write lost to trigger");
	a_write_ps: assert property (@(posedge i_clk) disable iff (i_reset)
		(wr_lo || wr_hi) |=> ps_q == `PS_ZERO)
		else $error("prescaler not cleared on write");
	a_wrap_flag: assert property (@(posedge i_clk) disable iff (i_reset)
		(ctrl_q[`CTL_RUN] && ps_out && cnt_q == `CNT_MAX && !trig_ok &&
		!wr_lo && !wr_hi) |=> ovf_q && cnt_q == `CNT_ZERO)
		else $error("wrap mishandled");
	a_stopped_hold: assert property (@(posedge i_clk) disable iff (i_reset)
		(!ctrl_q[`CTL_RUN] && !trig_ok && !wr_lo && !wr_hi) |=>
		cnt_q === $past(cnt_q))
		else $error("count moved while stopped");
	a_por_ctrl: assert property (@(posedge i_clk) disable iff (i_reset)
		(i_por_reset || i_brown_out_reset) |=> ctrl_q == `CTRL_RST)
		else $error("control not cleared");
	a_irq_gate: assert property (@(posedge i_clk) disable iff (i_reset)
		o_irq |-> $past(ovf_d) && $past(ien_d[`OVF_BIT]))
		else $error("irq without flag and enable");
	a_div8: assert property (@(posedge i_clk) disable iff (i_reset)
		(ctrl_q[`CTL_PS_HI:`CTL_PS_LO] == 2'b11 && ps_out) |->
		ps_q == 3'b111)
		else $error("prescale 1:8 wrong");
endmodule : timer16

// [sim/ext_clk_src.sv]
`timescale 1ns/1ps
// ==========================================
// far-side clock: an external oscillator or crystal
module ext_clk_src (
	// enable from the bench
	input wire logic i_run,
	// clock pin level
	output logic o_clk
);
	// stands low outside bursts so that no stray edge is counted
	// 160 ns period
	initial begin
		o_clk = 1'b0;
		forever begin
			#80;
			o_clk = i_run ? ~o_clk : 1'b0;
		end
	end
endmodule : ext_clk_src

// [sim/tb_top.sv]
`timescale 1ns/1ps
`include "tmr_cfg.svh"
module tb_top;
	// ==========================================
	// stimulus and observed signals
	logic clk = 1'b0;
	logic rst = 1'b1;
	// power-on reset accompanies the first reset so control starts cleared
	logic por = 1'b1;
	logic bor = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic tick = 1'b0;
	logic sleep = 1'b0;
	logic xrun = 1'b0;
	logic crun = 1'b0;
	logic cma = 1'b0;
	logic cmb = 1'b0;
	logic xclk, cclk, drive, irq, wake;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata, got;
	logic [3:0] ma = 4'h0;
	logic [3:0] mb = 4'h0;
	logic [15:0] count, base;
	int err_total = 0;
	int samples_checked = 0;
	int cyc = 0;
	int xrise = 0;
	// 100 MHz clock
	always #5 clk = ~clk;
	timer16 uut (.i_clk(clk), .i_reset(rst), .i_por_reset(por),
		.i_brown_out_reset(bor), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_insn_tick(tick),
		.i_sleep(sleep), .i_ext_clk(xclk), .i_crystal_in_pin(cclk),
		.o_crystal_drive_pin(drive), .i_cmp_a_mode(ma),
		.i_cmp_a_match(cma), .i_cmp_b_mode(mb), .i_cmp_b_match(cmb),
		.o_count(count), .o_irq(irq), .o_wake(wake));
	ext_clk_src u_ext (.i_run(xrun), .o_clk(xclk));
	ext_clk_src u_xtal (.i_run(crun), .o_clk(cclk));
	// crystal rising edges, the count that the counter must reach
	always @(posedge cclk) xrise++;
	// ==========================================
	// bus, check and report tasks
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 got = rdata;
	endtask : rd_reg
	task automatic chk_val(input logic [15:0] g, input logic [15:0] e);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %0t value %h expected %h", $time, g, e);
		end
	endtask : chk_val
	task automatic chk_bit(input logic g, input logic e);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("[FAIL] %0t flag %b expected %b", $time, g, e);
		end
	endtask : chk_bit
	task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
		rd_reg(a);
		chk_val({8'h00, got}, {8'h00, e});
	endtask : chk_reg
	// count port and both bytes; settle lets the sync path land
	task automatic chk_cnt(input logic [15:0] e);
		// bytes are read only while no increment can fall between them
		repeat (4) @(posedge clk);
		#1 chk_val(count, e);
		chk_reg(`OFS_CNT_LO, e[7:0]);
		chk_reg(`OFS_CNT_HI, e[15:8]);
	endtask : chk_cnt
	task automatic set_cnt(input logic [15:0] v);
		wr_reg(`OFS_CNT_LO, v[7:0]);
		wr_reg(`OFS_CNT_HI, v[15:8]);
	endtask : set_cnt
	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge clk);
			tick <= 1'b1;
			@(posedge clk);
			tick <= 1'b0;
			repeat (2) @(posedge clk);
		end
	endtask : ticks
	task automatic edges(input int n);
		xrun <= 1'b1;
		repeat (n) @(posedge xclk);
		xrun <= 1'b0;
	endtask : edges
	task automatic trig(input logic a);
		@(posedge clk);
		cma <= a;
		cmb <= ~a;
		@(posedge clk);
		cma <= 1'b0;
		cmb <= 1'b0;
	endtask : trig
	function automatic logic [7:0] ctl(input logic [1:0] ps,
		input logic [3:0] bits);
		return {2'b00, ps, bits};
	endfunction : ctl
	task automatic summarize;
		$display("checked %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : summarize
	// hang guard, well above the several hundred cycles needed
	always @(posedge clk) begin
		cyc++;
		if (cyc > 30000) begin
			err_total++;
			summarize();
		end
	end
	// ==========================================
	// main sequence
	initial begin
		void'($urandom(49));
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		por <= 1'b0;
		chk_reg(`OFS_CTRL, 8'h00);
		chk_reg(`OFS_FLAGS, 8'h00);
		chk_reg(`OFS_ENABLES, 8'h00);
		chk_reg(8'h55, 8'h00);
		$display("test reset values done");
		// wrap from FFFEh by three ticks
		set_cnt(16'hFFFE);
		wr_reg(`OFS_ENABLES, 8'h01);
		wr_reg(`OFS_CTRL, ctl(2'b00, 4'h1));
		ticks(3);
		chk_cnt(16'h0001);
		chk_reg(`OFS_FLAGS, 8'h01);
		chk_bit(irq, 1'b1);
		wr_reg(`OFS_ENABLES, 8'h00);
		repeat (2) @(posedge clk);
		#1 chk_bit(irq, 1'b0);
		wr_reg(`OFS_FLAGS, 8'h00);
		$display("test overflow done");
		// residue of 11 ticks must be cleared by the next count write
		for (int ps = 0; ps < 4; ps++) begin
			wr_reg(`OFS_CTRL, ctl(2'(ps), 4'h0));
			base = 16'($urandom_range(0, 16'hFF00));
			set_cnt(base);
			wr_reg(`OFS_CTRL, ctl(2'(ps), 4'h1));
			ticks(11);
			chk_cnt(base + 16'(11 >> ps));
		end
		wr_reg(`OFS_CTRL, 8'h00);
		ticks(2);
		chk_cnt(base + 16'(11 >> 3));
		$display("test prescale done");
		// special event triggers
		set_cnt(16'h5555);
		wr_reg(`OFS_CTRL, 8'h01);
		ma <= 4'($urandom_range(0, 10));
		mb <= `CMP_MODE_SPECIAL;
		trig(1'b1);
		chk_cnt(16'h5555);
		trig(1'b0);
		chk_cnt(16'h0000);
		chk_reg(`OFS_FLAGS, 8'h00);
		ma <= `CMP_MODE_SPECIAL;
		@(posedge clk);
		addr <= `OFS_CNT_LO;
		wdata <= 8'h5A;
		wr <= 1'b1;
		cma <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		cma <= 1'b0;
		chk_cnt(16'h005A);
		trig(1'b1);
		chk_cnt(16'h0000);
		$display("test trigger done");
		// external clock, synchronised then bypassed in sleep
		wr_reg(`OFS_CTRL, 8'h00);
		set_cnt(16'h0000);
		wr_reg(`OFS_CTRL, ctl(2'b00, 4'h3));
		edges(4);
		chk_cnt(16'h0004);
		sleep <= 1'b1;
		edges(3);
		chk_cnt(16'h0004);
		wr_reg(`OFS_CTRL, 8'h00);
		set_cnt(16'hFFFE);
		wr_reg(`OFS_ENABLES, 8'h01);
		wr_reg(`OFS_CTRL, ctl(2'b00, 4'h7));
		edges(3);
		chk_cnt(16'h0001);
		chk_bit(wake, 1'b1);
		trig(1'b1);
		chk_cnt(16'h0001);
		sleep <= 1'b0;
		$display("test external clock done");
		// crystal source
		wr_reg(`OFS_CTRL, 8'h00);
		set_cnt(16'h0000);
		wr_reg(`OFS_CTRL, ctl(2'b00, 4'hB));
		crun <= 1'b1;
		repeat (20) @(posedge clk);
		@(posedge cclk);
		#40 chk_bit(drive, 1'b0);
		@(negedge cclk);
		#40 chk_bit(drive, 1'b1);
		crun <= 1'b0;
		chk_cnt(16'(xrise));
		$display("test crystal done");
		// plain reset keeps control and count; POR and BOR clear control only
		wr_reg(`OFS_CTRL, 8'h00);
		set_cnt(16'hABCD);
		for (int k = 0; k < 3; k++) begin
			wr_reg(`OFS_CTRL, 8'h34);
			@(posedge clk);
			rst <= (k == 2);
			por <= (k == 0);
			bor <= (k == 1);
			repeat (2) @(posedge clk);
			rst <= 1'b0;
			por <= 1'b0;
			bor <= 1'b0;
			chk_reg(`OFS_CTRL, (k == 2) ? 8'h34 : 8'h00);
			chk_cnt(16'hABCD);
		end
		$display("test resets done");
		summarize();
	end
endmodule : tb_top
